// file: imove_pkg.sv
// Constants and types for the immediate and program-memory move unit
package imove_pkg;

    // ---------------------------------------------------------------
    // Immediate short move opcode layout
    // ---------------------------------------------------------------
    localparam logic [8:0] IMOVE_IMM_OPCODE = 9'h00F;
    localparam int IMOVE_IMM_OP_HI = 31;
    localparam int IMOVE_IMM_OP_LO = 23;
    localparam int IMOVE_IMM_HI = 22;
    localparam int IMOVE_IMM_LO = 7;
    localparam int IMOVE_DST_HI = 6;
    localparam int IMOVE_DST_LO = 0;

    // ---------------------------------------------------------------
    // Program memory move opcode layout
    // ---------------------------------------------------------------
    localparam logic [11:0] IMOVE_PM_OPCODE = 12'h016;
    localparam int IMOVE_PM_OP_HI = 31;
    localparam int IMOVE_PM_OP_LO = 20;
    localparam int IMOVE_MODE_HI = 19;
    localparam int IMOVE_MODE_LO = 17;
    localparam int IMOVE_RN_HI = 16;
    localparam int IMOVE_RN_LO = 14;
    localparam int IMOVE_MARK_BIT = 13;
    localparam int IMOVE_DIR_BIT = 12;
    localparam int IMOVE_MID_HI = 11;
    localparam int IMOVE_MID_LO = 7;
    localparam logic [4:0] IMOVE_MID_VAL = 5'h02;

    // ---------------------------------------------------------------
    // Register codes
    // ---------------------------------------------------------------
    localparam logic [3:0] IMOVE_GRP_SHORT = 4'h0;
    localparam logic [3:0] IMOVE_GRP_HIGH = 4'h3;
    localparam logic [3:0] IMOVE_GRP_EXTRA = 4'h4;
    localparam logic [3:0] IMOVE_GRP_ADDR = 4'h5;
    localparam logic [3:0] IMOVE_GRP_MODIF = 4'h7;
    localparam logic [6:0] IMOVE_STATUS_WORD = 7'h79;
    localparam logic [6:0] IMOVE_STACK_HIGH_WORD = 7'h7C;

    // ---------------------------------------------------------------
    // Addressing modes
    // ---------------------------------------------------------------
    localparam logic [2:0] IMOVE_AM_POST_DEC_N = 3'h0;
    localparam logic [2:0] IMOVE_AM_POST_INC_N = 3'h1;
    localparam logic [2:0] IMOVE_AM_POST_DEC = 3'h2;
    localparam logic [2:0] IMOVE_AM_POST_INC = 3'h3;
    localparam logic [2:0] IMOVE_AM_NO_UPDATE = 3'h4;
    localparam logic [2:0] IMOVE_AM_INDEXED_N = 3'h5;
    localparam logic [2:0] IMOVE_AM_ABSOLUTE = 3'h6;
    localparam logic [2:0] IMOVE_AM_PRE_DEC = 3'h7;
    localparam logic [2:0] IMOVE_ABS_RN = 3'h0;
    localparam logic [31:0] IMOVE_ONE = 32'h0000_0001;

    // ---------------------------------------------------------------
    // Status word fields
    // ---------------------------------------------------------------
    localparam int IMOVE_CC_HI = 7;
    localparam int IMOVE_CC_LO = 0;
    localparam int IMOVE_ES_HI = 15;
    localparam int IMOVE_ES_LO = 8;
    localparam int IMOVE_SF_HI = 20;
    localparam int IMOVE_SF_LO = 16;

    // ---------------------------------------------------------------
    // Timing in clock cycles and state machine
    // ---------------------------------------------------------------
    localparam logic [2:0] IMOVE_IMM_CYCLES = 3'h2;
    localparam logic [2:0] IMOVE_PM_CYCLES = 3'h6;
    localparam logic [2:0] IMOVE_CNT_MAX = 3'h7;

    typedef enum logic [2:0] {
        IMOVE_ST_IDLE = 3'b000,
        IMOVE_ST_EXT = 3'b001,
        IMOVE_ST_SRC = 3'b011,
        IMOVE_ST_MEM = 3'b010,
        IMOVE_ST_WR = 3'b110,
        IMOVE_ST_IMM = 3'b100
    } imove_state_e;

endpackage

// file: imove_unit.sv
// Decode and execute unit for immediate short and program-memory moves
`timescale 1ns/100ps

module imove_unit
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_i,
    output logic instr_ready_o,
    output logic illegal_o,
    output logic done_o,
    output logic ext_req_o,
    input wire logic ext_valid_i,
    input wire logic [31:0] ext_word_i,
    output logic [6:0] rf_sel_o,
    input wire logic [31:0] rf_rd_data_i,
    output logic rf_we_o,
    output logic [31:0] rf_wdata_o,
    output logic [2:0] address_register_sel_o,
    input wire logic [31:0] address_register_i,
    input wire logic [31:0] offset_register_i,
    output logic address_register_we_o,
    output logic [31:0] address_register_wdata_o,
    output logic stack_pointer_inc_o,
    output logic stack_pointer_dec_o,
    output logic pm_req_o,
    output logic pm_we_o,
    output logic [31:0] pm_addr_o,
    output logic [31:0] pm_wdata_o,
    input wire logic pm_ack_i,
    input wire logic [31:0] pm_rdata_i,
    output logic [7:0] condition_code_byte_o,
    output logic [7:0] exception_status_byte_o,
    output logic [4:0] sticky_flag_byte_o
);
    import imove_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        imove_state_e st;
        logic [2:0] cnt;
        logic dir_load;
        logic is_abs;
        logic [2:0] mode;
        logic [2:0] rn;
        logic [6:0] reg_code;
        logic [31:0] data;
        logic [31:0] ea;
        logic [31:0] an_val;
        logic ready;
        logic illegal;
        logic done;
        logic ext_req;
        logic rf_we;
        logic an_we;
        logic sp_inc;
        logic sp_dec;
        logic pm_req;
        logic pm_we;
        logic [7:0] cc;
        logic [7:0] es;
        logic [4:0] sf;
    } imove_state_s;

    imove_state_s s_q;
    imove_state_s s_d;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic code_valid(input logic [6:0] code);
        logic ok;
        ok = 1'b0;
        // Codes above the modifier group and below the status word are refused
        if (code[6:3] <= IMOVE_GRP_HIGH)
            ok = 1'b1;
        else if (code[6:3] == IMOVE_GRP_EXTRA)
            ok = 1'b1;
        else if (code[6:3] >= IMOVE_GRP_ADDR && code[6:3] <= IMOVE_GRP_MODIF)
            ok = 1'b1;
        else if (code >= IMOVE_STATUS_WORD)
            ok = 1'b1;
        return ok;
    endfunction

    // Linear arithmetic only; modulo addressing belongs to the address unit
    function automatic logic [63:0] ea_calc(input logic [2:0] mode,
                                            input logic [31:0] rn,
                                            input logic [31:0] nn);
        logic [31:0] ea;
        logic [31:0] nx;
        ea = rn;
        nx = rn;
        case (mode)
            IMOVE_AM_POST_DEC_N: nx = rn - nn;
            IMOVE_AM_POST_INC_N: nx = rn + nn;
            IMOVE_AM_POST_DEC: nx = rn - IMOVE_ONE;
            IMOVE_AM_POST_INC: nx = rn + IMOVE_ONE;
            IMOVE_AM_INDEXED_N: ea = rn + nn;
            IMOVE_AM_PRE_DEC:
            begin
                ea = rn - IMOVE_ONE;
                nx = ea;
            end
            default: ea = rn;
        endcase
        return {ea, nx};
    endfunction

    function automatic logic mode_updates(input logic [2:0] mode);
        return (mode != IMOVE_AM_NO_UPDATE) && (mode != IMOVE_AM_INDEXED_N)
            && (mode != IMOVE_AM_ABSOLUTE);
    endfunction

    // Only the stack high word moves the pointer; one compare serves
    // every place that raises a pointer pulse
    function automatic logic is_stack_high(input logic [6:0] code);
        return code == IMOVE_STACK_HIGH_WORD;
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    logic is_imm;
    logic is_pm;
    logic mode_ok;
    logic [6:0] dst;
    logic [63:0] ea_pair;

    always_comb
    begin
        dst = instr_i[IMOVE_DST_HI:IMOVE_DST_LO];
        is_imm = instr_i[IMOVE_IMM_OP_HI:IMOVE_IMM_OP_LO]
            == IMOVE_IMM_OPCODE;
        is_pm = instr_i[IMOVE_PM_OP_HI:IMOVE_PM_OP_LO] == IMOVE_PM_OPCODE
            && instr_i[IMOVE_MARK_BIT]
            && instr_i[IMOVE_MID_HI:IMOVE_MID_LO] == IMOVE_MID_VAL;
        // Absolute is the only alterable form of mode 6; others are immediate
        mode_ok = instr_i[IMOVE_MODE_HI:IMOVE_MODE_LO] != IMOVE_AM_ABSOLUTE
            || instr_i[IMOVE_RN_HI:IMOVE_RN_LO] == IMOVE_ABS_RN;
        ea_pair = ea_calc(s_q.mode, address_register_i, offset_register_i);

        s_d = s_q;
        s_d.illegal = 1'b0;
        s_d.done = 1'b0;
        s_d.rf_we = 1'b0;
        s_d.an_we = 1'b0;
        s_d.sp_inc = 1'b0;
        s_d.sp_dec = 1'b0;
        if (s_q.cnt != IMOVE_CNT_MAX)
            s_d.cnt = s_q.cnt + 3'h1;

        case (s_q.st)
            IMOVE_ST_IDLE:
            begin
                s_d.cnt = 3'h1;
                if (instr_valid_i && is_imm && code_valid(dst))
                begin
                    s_d.ready = 1'b0;
                    s_d.reg_code = dst;
                    // Raw bits even for short float registers
                    s_d.data = {{16{instr_i[IMOVE_IMM_HI]}},
                        instr_i[IMOVE_IMM_HI:IMOVE_IMM_LO]};
                    s_d.sp_inc = is_stack_high(dst);
                    s_d.st = IMOVE_ST_IMM;
                end
                else if (instr_valid_i && is_pm && mode_ok && code_valid(dst))
                begin
                    s_d.ready = 1'b0;
                    s_d.reg_code = dst;
                    s_d.dir_load = instr_i[IMOVE_DIR_BIT];
                    s_d.mode = instr_i[IMOVE_MODE_HI:IMOVE_MODE_LO];
                    s_d.rn = instr_i[IMOVE_RN_HI:IMOVE_RN_LO];
                    s_d.is_abs = instr_i[IMOVE_MODE_HI:IMOVE_MODE_LO]
                        == IMOVE_AM_ABSOLUTE;
                    if (s_d.is_abs)
                    begin
                        s_d.ext_req = 1'b1;
                        s_d.st = IMOVE_ST_EXT;
                    end
                    else
                        s_d.st = IMOVE_ST_SRC;
                end
                // A refused word leaves the unit idle; the pulse is its trace
                else if (instr_valid_i)
                    s_d.illegal = 1'b1;
            end
            IMOVE_ST_IMM:
            begin
                // Single write cycle keeps the whole move at two cycles
                if (s_q.reg_code == IMOVE_STATUS_WORD)
                begin
                    s_d.cc = s_q.data[IMOVE_CC_HI:IMOVE_CC_LO];
                    s_d.es = s_q.data[IMOVE_ES_HI:IMOVE_ES_LO];
                    s_d.sf = s_q.data[IMOVE_SF_HI:IMOVE_SF_LO];
                end
                else
                    s_d.rf_we = 1'b1;
                s_d.done = 1'b1;
                s_d.ready = 1'b1;
                s_d.st = IMOVE_ST_IDLE;
            end
            IMOVE_ST_EXT:
            begin
                if (ext_valid_i)
                begin
                    s_d.ea = ext_word_i;
                    s_d.ext_req = 1'b0;
                    s_d.st = IMOVE_ST_SRC;
                end
                else
                begin
                    // Waiting for the extension word counts as a wait
                    s_d.cnt = s_q.cnt;
                end
            end
            IMOVE_ST_SRC:
            begin
                if (!s_q.is_abs)
                begin
                    s_d.ea = ea_pair[63:32];
                    s_d.an_val = ea_pair[31:0];
                    s_d.an_we = mode_updates(s_q.mode);
                end
                if (!s_q.dir_load)
                begin
                    s_d.data = rf_rd_data_i;
                    // Pointer drops only after the stack word was sampled
                    s_d.sp_dec = is_stack_high(s_q.reg_code);
                end
                // Address and store data are registered with the request
                s_d.pm_req = 1'b1;
                s_d.pm_we = !s_q.dir_load;
                s_d.st = IMOVE_ST_MEM;
            end
            IMOVE_ST_MEM:
            begin
                if (pm_ack_i)
                begin
                    s_d.pm_req = 1'b0;
                    s_d.pm_we = 1'b0;
                    if (s_q.dir_load)
                    begin
                        s_d.data = pm_rdata_i;
                        s_d.sp_inc = is_stack_high(s_q.reg_code);
                    end
                    s_d.st = IMOVE_ST_WR;
                end
                else
                begin
                    // Hold the count so wait states add to the minimum
                    s_d.cnt = s_q.cnt;
                end
            end
            IMOVE_ST_WR:
            begin
                // Stretch to the documented minimum; waits add on top
                if (s_q.cnt >= IMOVE_PM_CYCLES - 3'h1)
                begin
                    if (s_q.dir_load && s_q.reg_code == IMOVE_STATUS_WORD)
                    begin
                        s_d.cc = s_q.data[IMOVE_CC_HI:IMOVE_CC_LO];
                        s_d.es = s_q.data[IMOVE_ES_HI:IMOVE_ES_LO];
                        s_d.sf = s_q.data[IMOVE_SF_HI:IMOVE_SF_LO];
                    end
                    else
                        s_d.rf_we = s_q.dir_load;
                    s_d.done = 1'b1;
                    s_d.ready = 1'b1;
                    s_d.st = IMOVE_ST_IDLE;
                end
            end
            default:
            begin
                s_d.ready = 1'b1;
                s_d.st = IMOVE_ST_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    // Only the ready flag leaves reset high: the unit comes up idle
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_q <= '0;
            s_q.st <= IMOVE_ST_IDLE;
            s_q.ready <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign instr_ready_o = s_q.ready;
    assign illegal_o = s_q.illegal;
    assign done_o = s_q.done;
    assign ext_req_o = s_q.ext_req;
    assign rf_sel_o = s_q.reg_code;
    assign rf_we_o = s_q.rf_we;
    assign rf_wdata_o = s_q.data;
    assign address_register_sel_o = s_q.rn;
    assign address_register_we_o = s_q.an_we;
    assign address_register_wdata_o = s_q.an_val;
    assign stack_pointer_inc_o = s_q.sp_inc;
    assign stack_pointer_dec_o = s_q.sp_dec;
    assign pm_req_o = s_q.pm_req;
    assign pm_we_o = s_q.pm_we;
    assign pm_addr_o = s_q.ea;
    assign pm_wdata_o = s_q.data;
    assign condition_code_byte_o = s_q.cc;
    assign exception_status_byte_o = s_q.es;
    assign sticky_flag_byte_o = s_q.sf;

endmodule

// file: imove_unit_asserts.sv
// Checker for the immediate and program move unit
`timescale 1ns/100ps
module imove_unit_asserts
    import imove_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic instr_ready_o,
    input wire logic illegal_o,
    input wire logic done_o,
    input wire logic [6:0] rf_sel_o,
    input wire logic rf_we_o,
    input wire logic [31:0] rf_wdata_o,
    input wire logic stack_pointer_inc_o,
    input wire logic stack_pointer_dec_o,
    input wire logic pm_req_o,
    input wire logic pm_we_o,
    input wire logic [31:0] pm_addr_o,
    input wire logic pm_ack_i,
    input wire logic [7:0] condition_code_byte_o
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    logic acc, imm, pm;
    logic [31:0] sext_q;
    assign acc = instr_valid_i && instr_ready_o;
    assign imm = instr_i[31:23] == IMOVE_IMM_OPCODE && instr_i[6:0] < 7'h40;
    assign pm = instr_i[31:20] == IMOVE_PM_OPCODE;
    // Held until done, since no new word is taken while busy
    always_ff @(posedge clk_i)
    begin
        if (acc)
            sext_q <= {{16{instr_i[22]}}, instr_i[22:7]};
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    imm_latency_a: assert property (acc && imm |-> ##2 done_o)
        else $error("immediate move not done after two cycles");
    imm_data_a: assert property (acc && imm |-> ##2 rf_we_o &&
        rf_wdata_o == sext_q) else $error("immediate write data wrong");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done held longer than one cycle");
    pm_min_time_a: assert property (acc && pm |=> !done_o [*5])
        else $error("program move finished too early");
    status_cause_a: assert property ($past(rst_n_i) &&
        condition_code_byte_o != $past(condition_code_byte_o) |->
        done_o && rf_sel_o == IMOVE_STATUS_WORD)
        else $error("status changed without status destination");
    sp_inc_a: assert property (stack_pointer_inc_o |-> !rf_we_o
        ##[1:4] rf_we_o && rf_sel_o == IMOVE_STACK_HIGH_WORD)
        else $error("stack increment not ahead of stack write");
    sp_dec_a: assert property (stack_pointer_dec_o |-> pm_we_o &&
        rf_sel_o == IMOVE_STACK_HIGH_WORD)
        else $error("stack decrement without stack source store");
    pm_hold_a: assert property (pm_req_o && !pm_ack_i |=>
        pm_req_o && $stable(pm_addr_o) && $stable(pm_we_o))
        else $error("memory request dropped or changed before ack");
    illegal_idle_a: assert property (illegal_o |-> instr_ready_o
        && !done_o) else $error("rejected word left the unit busy");
    write_done_a: assert property (rf_we_o |-> done_o)
        else $error("register write outside the done cycle");
endmodule

bind imove_unit imove_unit_asserts chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_ready_o(instr_ready_o), .illegal_o(illegal_o), .done_o(done_o),
    .rf_sel_o(rf_sel_o), .rf_we_o(rf_we_o), .rf_wdata_o(rf_wdata_o),
    .stack_pointer_inc_o(stack_pointer_inc_o),
    .stack_pointer_dec_o(stack_pointer_dec_o), .pm_req_o(pm_req_o),
    .pm_we_o(pm_we_o), .pm_addr_o(pm_addr_o), .pm_ack_i(pm_ack_i),
    .condition_code_byte_o(condition_code_byte_o));

// file: imove_partner.sv
// Model of register file, address registers and program memory
`timescale 1ns/100ps
module imove_partner
(
    input wire logic clk_i,
    input wire logic [6:0] rf_sel_i,
    input wire logic rf_we_i,
    input wire logic [31:0] rf_wdata_i,
    input wire logic [2:0] ar_sel_i,
    input wire logic ar_we_i,
    input wire logic [31:0] ar_wdata_i,
    input wire logic sp_inc_i,
    input wire logic sp_dec_i,
    input wire logic pm_req_i,
    input wire logic pm_we_i,
    input wire logic [31:0] pm_addr_i,
    input wire logic [31:0] pm_wdata_i,
    input wire logic [3:0] wait_i,
    output logic [31:0] rf_rd_o,
    output logic [31:0] ar_o,
    output logic [31:0] nr_o,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [31:0] rf [128];
    logic [31:0] ar [8];
    logic [31:0] mem [16];
    logic [31:0] last = 32'h0;
    logic [3:0] cnt = 4'h0;
    int sp = 0;
    initial
    begin
        for (int i = 0; i < 128; i++) rf[i] = 32'h5A00_0000 | 32'(i);
        for (int i = 0; i < 8; i++) ar[i] = 32'(i);
        for (int i = 0; i < 16; i++) mem[i] = 32'hC0DE_0000 | 32'(i);
    end
    assign rf_rd_o = rf[rf_sel_i];
    assign ar_o = ar[ar_sel_i];
    assign nr_o = 32'h0000_0002;
    // Slow memory: ack only after wait_i waiting cycles
    assign ack_o = pm_req_i && cnt == wait_i;
    // Released data is inverted so a stale word cannot pass for a read
    assign rdata_o = ack_o ? mem[pm_addr_i[3:0]] : ~last;
    always @(posedge clk_i)
    begin
        if (rf_we_i) rf[rf_sel_i] <= rf_wdata_i;
        if (ar_we_i) ar[ar_sel_i] <= ar_wdata_i;
        if (sp_inc_i) sp <= sp + 1;
        if (sp_dec_i) sp <= sp - 1;
        if (ack_o && pm_we_i) mem[pm_addr_i[3:0]] <= pm_wdata_i;
        if (ack_o) last <= rdata_o;
        cnt <= (pm_req_i && !ack_o) ? cnt + 4'h1 : 4'h0;
    end
endmodule

// file: imove_unit_test.sv
// Self-checking bench for the immediate and program move unit
`timescale 1ns/100ps
module imove_unit_test;
    import imove_pkg::*;
    logic clk_i = 0, rst_n_i = 0, instr_valid_i = 0, ext_valid_i = 0;
    logic [31:0] instr_i = 0, ext_word_i = 32'h0000_000A;
    logic instr_ready_o, illegal_o, done_o, ext_req_o, rf_we_o, pm_ack_i;
    logic ar_we, stack_pointer_inc_o, stack_pointer_dec_o, pm_req_o, pm_we_o;
    logic [6:0] rf_sel_o;
    logic [2:0] ar_sel;
    logic [31:0] rf_rd_data_i, rf_wdata_o, ar_val, nr_val, ar_wd;
    logic [31:0] pm_addr_o, pm_wdata_o, pm_rdata_i;
    logic [7:0] cc, es;
    logic [4:0] sf;
    logic [3:0] mem_wait = 4'h0;
    int miscompares = 0, total_checks = 0, cyc = 0, n;
    // Destination code and immediate of each plain case
    logic [22:0] rows [8] = '{{16'h8001, 7'h03}, {16'h7FFF, 7'h0F},
        {16'h0000, 7'h12}, {16'hFFFF, 7'h1E}, {16'h1234, 7'h2B},
        {16'hABCD, 7'h3F}, {16'h0042, 7'h7F}, {16'h0F0F, 7'h7A}};

    imove_unit dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .instr_ready_o(instr_ready_o), .illegal_o(illegal_o),
        .done_o(done_o), .ext_req_o(ext_req_o), .ext_valid_i(ext_valid_i),
        .ext_word_i(ext_word_i), .rf_sel_o(rf_sel_o),
        .rf_rd_data_i(rf_rd_data_i), .rf_we_o(rf_we_o),
        .rf_wdata_o(rf_wdata_o), .address_register_sel_o(ar_sel),
        .address_register_i(ar_val), .offset_register_i(nr_val),
        .address_register_we_o(ar_we), .address_register_wdata_o(ar_wd),
        .stack_pointer_inc_o(stack_pointer_inc_o),
        .stack_pointer_dec_o(stack_pointer_dec_o), .pm_req_o(pm_req_o),
        .pm_we_o(pm_we_o), .pm_addr_o(pm_addr_o), .pm_wdata_o(pm_wdata_o),
        .pm_ack_i(pm_ack_i), .pm_rdata_i(pm_rdata_i),
        .condition_code_byte_o(cc), .exception_status_byte_o(es),
        .sticky_flag_byte_o(sf));
    imove_partner pm_u (.clk_i(clk_i), .rf_sel_i(rf_sel_o),
        .rf_we_i(rf_we_o), .rf_wdata_i(rf_wdata_o), .ar_sel_i(ar_sel),
        .ar_we_i(ar_we), .ar_wdata_i(ar_wd), .sp_inc_i(stack_pointer_inc_o),
        .sp_dec_i(stack_pointer_dec_o), .pm_req_i(pm_req_o),
        .pm_we_i(pm_we_o), .pm_addr_i(pm_addr_o), .pm_wdata_i(pm_wdata_o),
        .wait_i(mem_wait), .rf_rd_o(rf_rd_data_i), .ar_o(ar_val),
        .nr_o(nr_val), .ack_o(pm_ack_i), .rdata_o(pm_rdata_i));

    always #5 clk_i = ~clk_i;
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    function automatic logic [31:0] pmw(input logic [2:0] m, r,
        input logic d, input logic [6:0] g);
        return {IMOVE_PM_OPCODE, m, r, 1'h1, d, IMOVE_MID_VAL, g};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("checks %0d, miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Offer one word to an idle unit; n counts cycles to done or refusal
    task run(input logic [31:0] w, output int n);
        @(posedge clk_i);
        instr_i <= w;
        instr_valid_i <= 1'h1;
        @(posedge clk_i);
        instr_valid_i <= 1'h0;
        // The accept edge is cycle one; a refusal shows right after it
        n = 1;
        #1;
        while (done_o !== 1'h1 && illegal_o !== 1'h1 && n < 40)
        begin
            @(posedge clk_i);
            n++;
            #1;
        end
        @(posedge clk_i);
        #1;
    endtask
    // Extension word follows a request one cycle late
    always @(posedge clk_i)
    begin
        ext_valid_i <= ext_req_o;
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            final_report;
        end
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        #1;
        chk(instr_ready_o, 1);
        for (int i = 0; i < 8; i++)
        begin
            run({IMOVE_IMM_OPCODE, rows[i]}, n);
            chk(n, 2);
            chk(pm_u.rf[rows[i][6:0]], {{16{rows[i][22]}}, rows[i][22:7]});
            chk({sf, es, cc}, 0);
        end
        run({IMOVE_IMM_OPCODE, 16'hFFFE, IMOVE_STACK_HIGH_WORD}, n);
        chk(pm_u.sp, 1);
        chk(pm_u.rf[7'h7C], 32'hFFFF_FFFE);
        run({IMOVE_IMM_OPCODE, 16'hA5C3, IMOVE_STATUS_WORD}, n);
        chk({sf, es, cc}, {5'h1F, 8'hA5, 8'hC3});
        run({IMOVE_IMM_OPCODE, 16'h0001, 7'h40}, n);
        chk(n, 1);
        run(32'hFFFF_FFFF, n);
        chk(n, 1);
        run(pmw(IMOVE_AM_ABSOLUTE, 3'h1, 1'h1, 7'h01), n);
        chk(n, 1);
        run(pmw(IMOVE_AM_POST_INC, 3'h1, 1'h0, 7'h05), n);
        chk(n, 6);
        chk(pm_u.mem[1], 32'h5A00_0005);
        chk(pm_u.ar[1], 2);
        mem_wait <= 4'h3;
        run(pmw(IMOVE_AM_NO_UPDATE, 3'h2, 1'h1, IMOVE_STACK_HIGH_WORD), n);
        chk(n, 9);
        chk(pm_u.rf[7'h7C], 32'hC0DE_0002);
        chk(pm_u.sp, 2);
        mem_wait <= 4'h0;
        run(pmw(IMOVE_AM_NO_UPDATE, 3'h0, 1'h0, IMOVE_STACK_HIGH_WORD), n);
        chk(pm_u.mem[0], 32'hC0DE_0002);
        chk(pm_u.sp, 1);
        run(pmw(IMOVE_AM_NO_UPDATE, 3'h3, 1'h1, IMOVE_STATUS_WORD), n);
        chk({sf, es, cc}, {5'h1E, 8'h00, 8'h03});
        run(pmw(IMOVE_AM_ABSOLUTE, IMOVE_ABS_RN, 1'h1, 7'h01), n);
        chk(pm_u.rf[1], 32'hC0DE_000A);
        chk(n >= 6, 1);
        // Reset during a stalled access must leave a clean idle unit
        mem_wait <= 4'hF;
        @(posedge clk_i);
        instr_i <= pmw(IMOVE_AM_NO_UPDATE, 3'h0, 1'h1, 7'h01);
        instr_valid_i <= 1'h1;
        @(posedge clk_i);
        instr_valid_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'h0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'h1;
        mem_wait <= 4'h0;
        @(posedge clk_i);
        #1;
        chk({instr_ready_o, pm_req_o, done_o, sf, es, cc}, 32'h0080_0000);
        run({IMOVE_IMM_OPCODE, 16'h0005, 7'h01}, n);
        chk(n, 2);
        final_report;
    end
endmodule
